/* File: hw/mfse_host.sv */
// Host end: Wishbone slave, sync and frame clock generator, register access
`timescale 1ns/100ps
`default_nettype none
module mfse_host
	import mfse_pkg::*;
#(
	parameter int SYNC_HALF = MFSE_DEF_SYNC_HALF,
	parameter int FRAME_HALF = MFSE_DEF_FRAME_HALF
)
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic irq_out,
	mfse_link_if.host link
);
	typedef enum logic {MFSE_ACC_IDLE, MFSE_ACC_WAIT} mfse_acc_t;

	// Sync and frame must be a power-of-two multiple of the 8-cycle phase
	if (SYNC_HALF < 4 || (SYNC_HALF & (SYNC_HALF - 1)) != 0 || SYNC_HALF > 256)
		$error("SYNC_HALF must be a power of two from 4 to 256");
	if (FRAME_HALF < SYNC_HALF || (FRAME_HALF & (FRAME_HALF - 1)) != 0 || FRAME_HALF > 256)
		$error("FRAME_HALF must be a power of two from SYNC_HALF to 256");

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------
	logic ack_q;
	logic [31:0] dat_q;
	logic [2:0] ctrl_q;
	logic [MFSE_IRQ_W-1:0] stat_q;
	logic [MFSE_IRQ_W-1:0] mask_q;
	logic [7:0] acc_rdata_q;
	logic req_q;
	logic we_q;
	logic [7:0] addr_q;
	logic [7:0] wdata_q;
	logic [2:0] ack_s_q;
	mfse_acc_t acc_q;
	logic [7:0] sync_cnt_q;
	logic sync_q;
	logic [7:0] frame_cnt_q;
	logic frame_q;
	logic shot_q;

	wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	wire [31:0] wdat = wb_dat_in & bmask;
	wire req = wb_cyc_in & wb_stb_in;
	wire wr = req & ack_q & wb_we_in;
	wire wr_ctrl = wr & (wb_adr_in == MFSE_WB_CTRL);
	wire wr_acc = wr & (wb_adr_in == MFSE_WB_ACC) & (wb_sel_in != 4'h0);
	wire wr_stat = wr & (wb_adr_in == MFSE_WB_IRQ_STAT);
	wire wr_mask = wr & (wb_adr_in == MFSE_WB_IRQ_MASK);
	wire busy = (acc_q == MFSE_ACC_WAIT);
	wire launch = wr_acc & ~busy;
	wire ack_evt = ack_s_q[1] ^ ack_s_q[2];
	wire frame_rise = frame_cnt_q == 8'h00 && (shot_q || ctrl_q[MFSE_HC_FRAME_CONT_BIT]) && !frame_q;
	wire [31:0] rd_mux = (wb_adr_in == MFSE_WB_CTRL) ? {29'h0, 1'b0, ctrl_q[1:0]} :
		(wb_adr_in == MFSE_WB_ACC) ? {busy, 23'h0, acc_rdata_q} :
		(wb_adr_in == MFSE_WB_IRQ_STAT) ? {30'h0, stat_q} :
		(wb_adr_in == MFSE_WB_IRQ_MASK) ? {30'h0, mask_q} : 32'h0;
	wire [MFSE_IRQ_W-1:0] stat_set = {frame_rise, ack_evt & busy};
	// Set beats clear when both land on one edge
	wire [MFSE_IRQ_W-1:0] stat_d = (stat_q & ~(wr_stat ? wdat[MFSE_IRQ_W-1:0] : 2'h0)) | stat_set;

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
			ctrl_q <= 3'h0;
			stat_q <= 2'h0;
			mask_q <= 2'h0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (req & ~ack_q)
				dat_q <= rd_mux;
			if (wr_ctrl)
				ctrl_q <= wdat[2:0];
			else
				ctrl_q[MFSE_HC_FRAME_SHOT_BIT] <= 1'b0;
			stat_q <= stat_d;
			if (wr_mask)
				mask_q <= wdat[MFSE_IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Device register access over the toggle handshake
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ack_s_q <= 3'h0;
			acc_q <= MFSE_ACC_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			acc_rdata_q <= 8'h00;
		end
		else
		begin
			ack_s_q <= {ack_s_q[1:0], link.ack_tgl};
			case (acc_q)
				MFSE_ACC_IDLE:
					if (launch)
					begin
						we_q <= wdat[MFSE_ACC_WE_BIT];
						addr_q <= wdat[MFSE_ACC_ADDR_LSB +: 8];
						wdata_q <= wdat[7:0];
						req_q <= ~req_q;
						acc_q <= MFSE_ACC_WAIT;
					end
				MFSE_ACC_WAIT:
					if (ack_evt)
					begin
						acc_rdata_q <= link.rdata;
						acc_q <= MFSE_ACC_IDLE;
					end
				default:
					acc_q <= MFSE_ACC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sync and frame clock generation
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync_cnt_q <= 8'h00;
			sync_q <= 1'b0;
			frame_cnt_q <= 8'h00;
			frame_q <= 1'b0;
			shot_q <= 1'b0;
		end
		else
		begin
			if (!ctrl_q[MFSE_HC_SYNC_RUN_BIT])
			begin
				sync_cnt_q <= 8'h00;
				sync_q <= 1'b0;
			end
			else if (sync_cnt_q == 8'(SYNC_HALF - 1))
			begin
				sync_cnt_q <= 8'h00;
				sync_q <= ~sync_q;
			end
			else
				sync_cnt_q <= sync_cnt_q + 8'h01;
			if (ctrl_q[MFSE_HC_FRAME_SHOT_BIT] & ~ctrl_q[MFSE_HC_FRAME_CONT_BIT] & ~frame_q)
				shot_q <= 1'b1;
			// Each frame high phase lasts FRAME_HALF - 1 cycles, well over two data clocks
			if (frame_q | shot_q | ctrl_q[MFSE_HC_FRAME_CONT_BIT])
			begin
				if (frame_cnt_q == 8'(FRAME_HALF - 1))
				begin
					frame_cnt_q <= 8'h00;
					frame_q <= ~frame_q;
					if (frame_q)
						shot_q <= 1'b0;
				end
				else
				begin
					frame_cnt_q <= frame_cnt_q + 8'h01;
					if (frame_rise)
						frame_q <= 1'b1;
				end
			end
		end
	end

	assign link.sync_clk = sync_q;
	assign link.frame = frame_q;
	assign link.req_tgl = req_q;
	assign link.we = we_q;
	assign link.addr = addr_q;
	assign link.wdata = wdata_q;
	assign wb_dat_out = dat_q;
	assign wb_ack_out = ack_q;
	assign irq_out = |(stat_q & mask_q);
endmodule
`default_nettype wire

/* File: pkg/mfse_pkg.sv */
// Shared constants of the multichip frame sync engine and its host end
`default_nettype none
package mfse_pkg;
	// ----------------------------------------------------------------
	// Device registers, reached over the link
	// ----------------------------------------------------------------
	localparam logic [7:0] MFSE_REG_SYNC_CTRL = 8'h21;
	localparam logic [7:0] MFSE_REG_FRAME_CFG = 8'h22;
	localparam int MFSE_CTRL_EN_BIT = 0;
	localparam int MFSE_CTRL_EDGE_BIT = 1;
	localparam int MFSE_CFG_MODE_LSB = 0;
	localparam int MFSE_CFG_ONESHOT_BIT = 2;
	localparam int MFSE_CFG_RCVD_BIT = 3;
	localparam int MFSE_CFG_SLIP_BIT = 4;
	localparam logic [1:0] MFSE_SYNC_CTRL_RST = 2'h0;
	localparam logic [2:0] MFSE_FRAME_CFG_RST = 3'h4;
	localparam logic [1:0] MFSE_MODE_FIFO = 2'h0;
	localparam logic [1:0] MFSE_MODE_FIFO_OSC = 2'h1;
	localparam logic [1:0] MFSE_MODE_MONITOR = 2'h3;
	localparam int MFSE_PHASE_W = 3;
	localparam logic [MFSE_PHASE_W-1:0] MFSE_PHASE_ZERO = 3'h0;
	// ----------------------------------------------------------------
	// Host registers, reached over Wishbone
	// ----------------------------------------------------------------
	localparam logic [3:0] MFSE_WB_CTRL = 4'h0;
	localparam logic [3:0] MFSE_WB_ACC = 4'h4;
	localparam logic [3:0] MFSE_WB_IRQ_STAT = 4'h8;
	localparam logic [3:0] MFSE_WB_IRQ_MASK = 4'hc;
	localparam int MFSE_HC_SYNC_RUN_BIT = 0;
	localparam int MFSE_HC_FRAME_CONT_BIT = 1;
	localparam int MFSE_HC_FRAME_SHOT_BIT = 2;
	localparam int MFSE_ACC_ADDR_LSB = 8;
	localparam int MFSE_ACC_WE_BIT = 16;
	localparam int MFSE_ACC_BUSY_BIT = 31;
	localparam int MFSE_IRQ_W = 2;
	localparam int MFSE_IRQ_DONE_BIT = 0;
	localparam int MFSE_IRQ_FRAME_BIT = 1;
	localparam int MFSE_DEF_SYNC_HALF = 4;
	localparam int MFSE_DEF_FRAME_HALF = 16;
endpackage
`default_nettype wire

/* File: pkg/mfse_link_if.sv */
// Link between the host end and the sync engine device end
`timescale 1ns/100ps
`default_nettype none
interface mfse_link_if;
	logic sync_clk;
	logic frame;
	logic req_tgl;
	logic ack_tgl;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev (input sync_clk, frame, req_tgl, we, addr, wdata, output ack_tgl, rdata);
	modport host (output sync_clk, frame, req_tgl, we, addr, wdata, input ack_tgl, rdata);
endinterface
`default_nettype wire

/* File: hw/mfse_device.sv */
// Device end: sync clock capture, frame reset engine and its registers
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Sampled sync clock realigns internal clock phase
// - Continuous mode resets FIFO on every frame
// - Mode 11b: sync once, then only monitor
// - Sync capture edge selectable, falling by default
// - Sync clock is data rate over eight or slower
// - Frame resets FIFO, one-shot or continuous
// - Frame pulse longer than one/two data clocks
// - Continuous frame at most data rate over eight
// - Modes FIFO-only and FIFO-plus-oscillator reset
// - Config bit 2 picks one-shot or continuous
// - Control bit 0 enables the engine
// - Status bit shows a frame was received
// - Host follows the documented bring-up order
// - With PLL, lock first, 2x interpolation only
// - Leave engine off for loose alignment needs
// - System sends frame and sync to all devices
module mfse_device
	import mfse_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	mfse_link_if.dev link,
	output logic fifo_reset_out,
	output logic osc_reset_out,
	output logic [MFSE_PHASE_W-1:0] clk_phase_out,
	output logic engine_on_out
);
	typedef enum logic [1:0] {MFSE_ENG_OFF, MFSE_ENG_ARMED, MFSE_ENG_DONE} mfse_eng_t;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sync_rise_q;
	logic [1:0] sync_fall_q;
	logic sync_prev_q;
	logic [2:0] frame_s_q;
	logic [2:0] req_s_q;

	// Falling capture gets its own chain so the two first stages are never muxed
	always_ff @(negedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			sync_fall_q <= 2'h0;
		else
			sync_fall_q <= {sync_fall_q[0], link.sync_clk};
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync_rise_q <= 2'h0;
			frame_s_q <= 3'h0;
			req_s_q <= 3'h0;
		end
		else
		begin
			sync_rise_q <= {sync_rise_q[0], link.sync_clk};
			frame_s_q <= {frame_s_q[1:0], link.frame};
			req_s_q <= {req_s_q[1:0], link.req_tgl};
		end
	end

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic en_q;
	logic edge_rise_q;
	logic [1:0] mode_q;
	logic oneshot_q;
	logic rcvd_q;
	logic slip_q;
	logic ack_q;
	logic [7:0] rdata_q;
	logic [MFSE_PHASE_W-1:0] phase_q;
	logic fifo_rst_q;
	logic osc_rst_q;
	mfse_eng_t eng_q;
	mfse_eng_t eng_d;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire sync_lvl = edge_rise_q ? sync_rise_q[1] : sync_fall_q[1];
	wire sync_edge = sync_lvl & ~sync_prev_q;
	wire frame_edge = frame_s_q[1] & ~frame_s_q[2];
	wire req_evt = req_s_q[1] ^ req_s_q[2];
	wire monitor = (mode_q == MFSE_MODE_MONITOR);
	wire done = (eng_q == MFSE_ENG_DONE);
	wire realign = en_q & sync_edge & ~(monitor & done);
	wire repeat_ok = ~oneshot_q & ~monitor;
	wire frame_act = en_q & frame_edge & ((eng_q == MFSE_ENG_ARMED) | (done & repeat_ok));
	// An aligned sync edge finds the counter about to wrap, so test the next value
	wire [MFSE_PHASE_W-1:0] phase_inc = phase_q + MFSE_PHASE_W'(1);
	wire slip_evt = en_q & monitor & done & sync_edge & (phase_inc != MFSE_PHASE_ZERO);
	wire wr_ctrl = req_evt & link.we & (link.addr == MFSE_REG_SYNC_CTRL);
	wire wr_cfg = req_evt & link.we & (link.addr == MFSE_REG_FRAME_CFG);
	wire [7:0] ctrl_rd = {6'h00, edge_rise_q, en_q};
	wire [7:0] cfg_rd = {3'h0, slip_q, rcvd_q, oneshot_q, mode_q};
	wire [7:0] rd_val = (link.addr == MFSE_REG_SYNC_CTRL) ? ctrl_rd :
		(link.addr == MFSE_REG_FRAME_CFG) ? cfg_rd : 8'h00;
	// The disable clear is applied after the set, so an event while disabled is dropped
	wire rcvd_d = en_q & (rcvd_q | frame_edge);
	wire slip_d = en_q & (slip_q | slip_evt);

	always_comb
	begin
		eng_d = eng_q;
		case (eng_q)
			MFSE_ENG_OFF:
				if (en_q)
					eng_d = MFSE_ENG_ARMED;
			MFSE_ENG_ARMED:
				if (!en_q)
					eng_d = MFSE_ENG_OFF;
				else if (frame_act)
					eng_d = MFSE_ENG_DONE;
			MFSE_ENG_DONE:
				if (!en_q)
					eng_d = MFSE_ENG_OFF;
			default:
				eng_d = MFSE_ENG_OFF;
		endcase
	end

	// ----------------------------------------------------------------
	// Register file over the link handshake
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			en_q <= MFSE_SYNC_CTRL_RST[MFSE_CTRL_EN_BIT];
			edge_rise_q <= MFSE_SYNC_CTRL_RST[MFSE_CTRL_EDGE_BIT];
			mode_q <= MFSE_FRAME_CFG_RST[1:0];
			oneshot_q <= MFSE_FRAME_CFG_RST[MFSE_CFG_ONESHOT_BIT];
		end
		else
		begin
			if (wr_ctrl)
			begin
				en_q <= link.wdata[MFSE_CTRL_EN_BIT];
				edge_rise_q <= link.wdata[MFSE_CTRL_EDGE_BIT];
			end
			if (wr_cfg)
			begin
				mode_q <= link.wdata[MFSE_CFG_MODE_LSB +: 2];
				oneshot_q <= link.wdata[MFSE_CFG_ONESHOT_BIT];
			end
		end
	end

	// Read data is registered on the same edge that toggles ack
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rdata_q <= 8'h00;
			ack_q <= 1'b0;
		end
		else if (req_evt)
		begin
			rdata_q <= rd_val;
			ack_q <= ~ack_q;
		end
	end

	// ----------------------------------------------------------------
	// Sync engine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync_prev_q <= 1'b0;
			phase_q <= MFSE_PHASE_ZERO;
			eng_q <= MFSE_ENG_OFF;
			rcvd_q <= 1'b0;
			slip_q <= 1'b0;
			fifo_rst_q <= 1'b0;
			osc_rst_q <= 1'b0;
		end
		else
		begin
			sync_prev_q <= sync_lvl;
			// Sync edges come every multiple of eight cycles, so a free
			// counter realigned on them lands on zero at each later edge
			phase_q <= realign ? MFSE_PHASE_ZERO : phase_inc;
			eng_q <= eng_d;
			rcvd_q <= rcvd_d;
			slip_q <= slip_d;
			fifo_rst_q <= frame_act;
			osc_rst_q <= frame_act & (mode_q == MFSE_MODE_FIFO_OSC);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.ack_tgl = ack_q;
	assign link.rdata = rdata_q;
	assign fifo_reset_out = fifo_rst_q;
	assign osc_reset_out = osc_rst_q;
	assign clk_phase_out = phase_q;
	assign engine_on_out = en_q;
endmodule
`default_nettype wire

/* File: testbench/mfse_link_assertions.sv */
// Concurrent checks on the link and the device end outputs
`timescale 1ns/100ps
`default_nettype none
module mfse_link_assertions
	import mfse_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic sync_clk,
	input wire logic frame,
	input wire logic req_tgl,
	input wire logic ack_tgl,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic fifo_reset_out,
	input wire logic osc_reset_out,
	input wire logic [MFSE_PHASE_W-1:0] clk_phase_out,
	input wire logic engine_on_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// Repetition counts assume SYNC_HALF=4 and FRAME_HALF=16
	link_ack_a: assert property ($changed(req_tgl) |-> ##[2:5] $changed(ack_tgl))
		else $error("link ack missing");
	req_hold_a: assert property ((req_tgl != ack_tgl) && ($past(req_tgl) != $past(ack_tgl))
		|-> $stable({we, addr, wdata}))
		else $error("link request moved while pending");
	fifo_pulse_a: assert property (fifo_reset_out |=> !fifo_reset_out)
		else $error("fifo reset longer than one cycle");
	osc_with_fifo_a: assert property (osc_reset_out |-> fifo_reset_out)
		else $error("oscillator reset without fifo reset");
	fifo_cause_a: assert property (fifo_reset_out |-> engine_on_out && $past(frame, 2))
		else $error("fifo reset without frame or enable");
	// Two cycles after a rising sync with falling capture, three with rising capture
	phase_align_a: assert property (engine_on_out && $rose(sync_clk)
		|-> ##[2:3] (clk_phase_out == MFSE_PHASE_ZERO))
		else $error("phase not realigned by sync");
	sync_period_a: assert property ($changed(sync_clk) |=> $stable(sync_clk) [*3])
		else $error("sync half period too short");
	frame_width_a: assert property ($rose(frame) |=> frame [*8])
		else $error("frame pulse too short");
	cover property (fifo_reset_out);
	cover property (osc_reset_out);
	cover property ($changed(ack_tgl));
endmodule
`default_nettype wire

/* File: testbench/mfse_tb.sv */
// Self-checking bench joining the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module mfse_tb
	import mfse_pkg::*;
;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [31:0] wb_wd = 32'h0;
	logic [31:0] wb_rd;
	logic wb_ack;
	logic irq;
	logic fifo_rst;
	logic osc_rst;
	logic eng_on;
	logic [MFSE_PHASE_W-1:0] phase;
	logic [31:0] rd;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int fifo_n = 0;
	int osc_n = 0;

	always #12.5 core_clk_in = ~core_clk_in;

	mfse_link_if link();
	mfse_host #(.SYNC_HALF(4), .FRAME_HALF(16)) u_mfse_host (.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(4'hf), .wb_dat_in(wb_wd), .wb_dat_out(wb_rd),
		.wb_ack_out(wb_ack), .irq_out(irq), .link(link));
	mfse_device u_mfse_device (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(link),
		.fifo_reset_out(fifo_rst), .osc_reset_out(osc_rst), .clk_phase_out(phase),
		.engine_on_out(eng_on));
	mfse_link_assertions u_mfse_link_assertions (.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in), .sync_clk(link.sync_clk), .frame(link.frame),
		.req_tgl(link.req_tgl), .ack_tgl(link.ack_tgl), .we(link.we), .addr(link.addr),
		.wdata(link.wdata), .fifo_reset_out(fifo_rst), .osc_reset_out(osc_rst),
		.clk_phase_out(phase), .engine_on_out(eng_on));

	// ----------------------------------------------------------------
	// Report and comparison
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Pulse counting also bounds the whole run
	always @(posedge core_clk_in)
	begin
		cycles++;
		if (fifo_rst === 1'b1)
			fifo_n++;
		if (osc_rst === 1'b1)
			osc_n++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Bus and link access
	// ----------------------------------------------------------------
	// Only the global cycle ceiling ends a wait for ack
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
		@(posedge core_clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wd <= wd;
		@(posedge core_clk_in);
		while (wb_ack !== 1'b1)
			@(posedge core_clk_in);
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk_in);
		check("wb ack drop", 32'h0, {31'h0, wb_ack});
	endtask

	// Device access through the host: start it, then poll until not busy
	task automatic dev(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb(1'b1, MFSE_WB_ACC, {15'h0, we, a, d});
		do
		begin
			wb(1'b0, MFSE_WB_ACC, 32'h0);
			n++;
		end
		while (rd[MFSE_ACC_BUSY_BIT] !== 1'b0 && n < 30);
		if (n >= 30)
			check("link busy", 32'h0, 32'h1);
	endtask

	task automatic wait_fifo(input int want);
		int n;
		n = 0;
		while (fifo_n < want && n < 400)
		begin
			@(posedge core_clk_in);
			n++;
		end
		check("fifo pulses", want, fifo_n);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		dev(1'b0, MFSE_REG_SYNC_CTRL, 8'h00);
		check("ctrl reset", 32'h0, {24'h0, rd[7:0]});
		dev(1'b0, MFSE_REG_FRAME_CFG, 8'h00);
		check("cfg reset", 32'h4, {24'h0, rd[7:0]});
		dev(1'b1, 8'h30, 8'hff);
		dev(1'b0, 8'h30, 8'h00);
		check("dev unmapped", 32'h0, {24'h0, rd[7:0]});
		wb(1'b0, 4'h2, 32'h0);
		check("wb unmapped", 32'h0, rd);
		check("engine off", 32'h0, {31'h0, eng_on});
	endtask

	task automatic t_irq();
		wb(1'b0, MFSE_WB_IRQ_STAT, 32'h0);
		check("stat done", 32'h1, rd);
		check("irq masked", 32'h0, {31'h0, irq});
		wb(1'b1, MFSE_WB_IRQ_MASK, 32'h1);
		check("irq on", 32'h1, {31'h0, irq});
		wb(1'b1, MFSE_WB_IRQ_STAT, 32'h1);
		check("irq cleared", 32'h0, {31'h0, irq});
		wb(1'b1, MFSE_WB_IRQ_MASK, 32'h2);
	endtask

	task automatic t_oneshot();
		wb(1'b1, MFSE_WB_CTRL, 32'h1);
		dev(1'b1, MFSE_REG_FRAME_CFG, 8'h04);
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h01);
		fifo_n = 0;
		osc_n = 0;
		wb(1'b1, MFSE_WB_CTRL, 32'h5);
		wait_fifo(1);
		check("osc fifo mode", 32'h0, osc_n);
		check("irq frame", 32'h1, {31'h0, irq});
		repeat (60) @(posedge core_clk_in);
		wb(1'b1, MFSE_WB_CTRL, 32'h5);
		repeat (60) @(posedge core_clk_in);
		check("one shot once", 32'h1, fifo_n);
		dev(1'b0, MFSE_REG_FRAME_CFG, 8'h00);
		check("received", 32'hc, {24'h0, rd[7:0]});
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h00);
		dev(1'b0, MFSE_REG_FRAME_CFG, 8'h00);
		check("received cleared", 32'h4, {24'h0, rd[7:0]});
		wb(1'b1, MFSE_WB_IRQ_STAT, 32'h3);
		check("irq frame clear", 32'h0, {31'h0, irq});
	endtask

	task automatic t_cont();
		dev(1'b1, MFSE_REG_FRAME_CFG, 8'h01);
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h01);
		fifo_n = 0;
		osc_n = 0;
		wb(1'b1, MFSE_WB_CTRL, 32'h3);
		wait_fifo(3);
		wb(1'b1, MFSE_WB_CTRL, 32'h1);
		repeat (40) @(posedge core_clk_in);
		check("osc with fifo", fifo_n, osc_n);
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h00);
	endtask

	task automatic t_mon();
		dev(1'b1, MFSE_REG_FRAME_CFG, 8'h03);
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h03);
		dev(1'b0, MFSE_REG_SYNC_CTRL, 8'h00);
		check("edge select", 32'h3, {24'h0, rd[7:0]});
		fifo_n = 0;
		wb(1'b1, MFSE_WB_CTRL, 32'h3);
		repeat (150) @(posedge core_clk_in);
		check("monitor once", 32'h1, fifo_n);
		dev(1'b0, MFSE_REG_FRAME_CFG, 8'h00);
		check("monitor status", 32'hb, {24'h0, rd[7:0]});
		// Falling capture sees sync one cycle early, so the monitor must flag a slip
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h01);
		repeat (16) @(posedge core_clk_in);
		dev(1'b0, MFSE_REG_FRAME_CFG, 8'h00);
		check("sync slip", 32'h1b, {24'h0, rd[7:0]});
		wb(1'b1, MFSE_WB_CTRL, 32'h1);
		dev(1'b1, MFSE_REG_SYNC_CTRL, 8'h00);
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		t_regs();
		t_irq();
		t_oneshot();
		t_cont();
		t_mon();
		wrap_up();
	end
endmodule
`default_nettype wire
